//--- common/cmx_pkg.sv
// package: offsets, field positions, write mask, reset values and synchroniser depth
package cmx_pkg;
	localparam logic [9:0] CMX_CMP_CTRL_OFS  = 10'h1F8;
	localparam logic [9:0] CMX_EXT_EN_OFS    = 10'h1FA;
	localparam logic [9:0] CMX_IRQ_STAT_OFS  = 10'h1FC;
	localparam logic [9:0] CMX_IRQ_CLR_OFS   = 10'h1FD;
	localparam logic [9:0] CMX_IRQ_EN_OFS    = 10'h1FE;
	localparam logic [9:0] CMX_POL_OFS       = 10'h1FF;
	localparam int         CMX_CMP1_EN_BIT   = 0;
	localparam int         CMX_CMP1_RES_BIT  = 3;
	localparam int         CMX_CMP3_EN_BIT   = 4;
	localparam int         CMX_CMP3_RES_BIT  = 7;
	localparam logic [7:0] CMX_CTRL_WMASK    = 8'h11;
	localparam logic [7:0] CMX_RESET_VAL     = 8'h00;
	localparam logic [7:0] CMX_UNMAPPED_VAL  = 8'h00;
	localparam int         CMX_SYNC_STAGES   = 2;
endpackage : cmx_pkg

//--- common/cmx_sync_if.sv
// interface: synchroniser hookup between top and leaf
`timescale 1ns/1ps
`default_nettype none
interface cmx_sync_if;
	logic async_in;
	logic sync_out;
	modport leaf (input async_in, output sync_out);
	modport user (output async_in, input sync_out);
endinterface : cmx_sync_if
`default_nettype wire

//--- verilog/cmx_sync.sv
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module cmx_sync
	import cmx_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	cmx_sync_if.leaf  port
);
	typedef struct packed {
		logic meta;
		logic stable;
	} cmx_sync_state_type;
	cmx_sync_state_type state_reg;
	cmx_sync_state_type state_next;
	always_comb begin
		state_next = state_reg;
		if (ce) begin
			state_next.meta   = port.async_in;
			state_next.stable = state_reg.meta;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign port.sync_out = state_reg.stable;
endmodule : cmx_sync
`default_nettype wire

//--- verilog/cmx_ctrl.sv
// comparator and external input control register block
`timescale 1ns/1ps
`default_nettype none
module cmx_ctrl
	import cmx_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [9:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	input  wire logic       cmp_one_raw,
	input  wire logic       cmp_three_raw,
	input  wire logic [3:0] ext_in_raw,
	output var  logic       cmp_one_enable,
	output var  logic       cmp_three_enable,
	output var  logic [3:0] request_pending_flag,
	output var  logic       irq
);
	// ==========================================================
	// synchronisers
	cmx_sync_if cs1 ();
	cmx_sync_if cs3 ();
	cmx_sync_if es [4] ();
	assign cs1.async_in = cmp_one_raw;
	assign cs3.async_in = cmp_three_raw;
	cmx_sync u_s1 (.clk(clk), .rst(rst), .ce(ce), .port(cs1));
	cmx_sync u_s3 (.clk(clk), .rst(rst), .ce(ce), .port(cs3));
	logic [3:0] ext_sync;
	genvar g;
	for (g = 0; g < 4; g++) begin : g_ext
		assign es[g].async_in = ext_in_raw[g];
		cmx_sync u_se (.clk(clk), .rst(rst), .ce(ce), .port(es[g]));
		assign ext_sync[g] = es[g].sync_out;
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] ext_en;
		logic [3:0] edge_polarity_select;
		logic [3:0] ext_prev;
		logic       c1_prev;
		logic       c3_prev;
		logic [5:0] stat;
		logic [5:0] irq_en;
		logic [7:0] rdata;
		logic       irq;
	} cmx_state_type;
	cmx_state_type s_reg;
	cmx_state_type s_next;

	logic       res1;
	logic       res3;
	logic [5:0] ev;
	logic [5:0] clr;
	logic [7:0] ctrl_view;
	logic       en_write;

	always_comb begin
		// disabled channel reads zero
		res1 = cs1.sync_out & s_reg.ctrl[CMX_CMP1_EN_BIT];
		res3 = cs3.sync_out & s_reg.ctrl[CMX_CMP3_EN_BIT];
		ctrl_view = s_reg.ctrl & CMX_CTRL_WMASK;
		ctrl_view[CMX_CMP1_RES_BIT] = res1;
		ctrl_view[CMX_CMP3_RES_BIT] = res3;
		en_write = wr && addr == CMX_EXT_EN_OFS;
		for (int i = 0; i < 4; i++) begin
			// pol 1: falling edge; both-edge bit overrides
			ev[i] = s_reg.ext_en[2*i] && (
				(s_reg.ext_en[2*i+1] && ext_sync[i] != s_reg.ext_prev[i]) ||
				(!s_reg.ext_en[2*i+1] && (s_reg.edge_polarity_select[i] ?
					(!ext_sync[i] && s_reg.ext_prev[i]) :
					(ext_sync[i] && !s_reg.ext_prev[i]))));
			// writing a 1 to a clear enable bit in the enable register raises the request
			if (en_write && wdata[2*i] && !s_reg.ext_en[2*i]) begin
				ev[i] = 1'b1;
			end
		end
		ev[4] = res1 && !s_reg.c1_prev;
		ev[5] = res3 && !s_reg.c3_prev;
		clr = (wr && addr == CMX_IRQ_CLR_OFS) ? wdata[5:0] : 6'h00;
		s_next = s_reg;
		if (ce) begin
			s_next.ext_prev = ext_sync;
			s_next.c1_prev  = res1;
			s_next.c3_prev  = res3;
			// set wins over clear
			s_next.stat = (s_reg.stat & ~clr) | ev;
			s_next.irq  = |(s_next.stat & s_reg.irq_en);
			s_next.rdata = 8'h00;
			if (wr) begin
				case (addr)
					CMX_CMP_CTRL_OFS: begin
						s_next.ctrl = wdata & CMX_CTRL_WMASK;
					end
					CMX_EXT_EN_OFS: begin
						s_next.ext_en = wdata;
					end
					CMX_IRQ_EN_OFS: begin
						s_next.irq_en = wdata[5:0];
					end
					CMX_POL_OFS: begin
						s_next.edge_polarity_select = wdata[3:0];
					end
					default: begin
					end
				endcase
			end
			if (rd) begin
				case (addr)
					CMX_CMP_CTRL_OFS: s_next.rdata = ctrl_view;
					CMX_EXT_EN_OFS:   s_next.rdata = s_reg.ext_en;
					CMX_IRQ_STAT_OFS: s_next.rdata = {2'b00, s_reg.stat};
					CMX_IRQ_EN_OFS:   s_next.rdata = {2'b00, s_reg.irq_en};
					CMX_POL_OFS:      s_next.rdata = {4'h0, s_reg.edge_polarity_select};
					default:          s_next.rdata = CMX_UNMAPPED_VAL;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata                = s_reg.rdata;
	assign cmp_one_enable       = s_reg.ctrl[CMX_CMP1_EN_BIT];
	assign cmp_three_enable     = s_reg.ctrl[CMX_CMP3_EN_BIT];
	assign request_pending_flag = s_reg.stat[3:0];
	assign irq                  = s_reg.irq;

	// ==========================================================
	// assertions
	sequence en_wr_s;
		ce && wr && addr == CMX_EXT_EN_OFS && wdata[0] && !s_reg.ext_en[0];
	endsequence
	ctrl_en_a: assert property (@(posedge clk) disable iff (rst)
		ce && wr && addr == CMX_CMP_CTRL_OFS |=> cmp_one_enable == $past(wdata[0]))
		else $error("comparator one enable not stored");
	res_one_a: assert property (@(posedge clk) disable iff (rst)
		ce && rd && addr == CMX_CMP_CTRL_OFS && !cmp_one_enable |=> !rdata[3])
		else $error("disabled channel one reads high");
	ctrl_three_a: assert property (@(posedge clk) disable iff (rst)
		ce && wr && addr == CMX_CMP_CTRL_OFS |=> cmp_three_enable == $past(wdata[4]))
		else $error("comparator three enable not stored");
	res_three_a: assert property (@(posedge clk) disable iff (rst)
		ce && rd && addr == CMX_CMP_CTRL_OFS && !cmp_three_enable |=> !rdata[7])
		else $error("disabled channel three reads high");
	ext_off_a: assert property (@(posedge clk) disable iff (rst)
		ce && !s_reg.ext_en[0] && !(en_write && wdata[0]) &&
		!s_reg.stat[0] |=> !request_pending_flag[0])
		else $error("disabled input raised a request");
	both_edge_a: assert property (@(posedge clk) disable iff (rst)
		ce && s_reg.ext_en[1:0] == 2'b11 && ext_sync[0] != s_reg.ext_prev[0]
		|=> request_pending_flag[0])
		else $error("both-edge input missed an edge");
	spur_req_a: assert property (@(posedge clk) disable iff (rst)
		en_wr_s |=> request_pending_flag[0])
		else $error("enable write did not raise request");
	sync_lat_a: assert property (@(posedge clk) disable iff (rst)
		$past(ce) && $past(ce, 2) && cmp_one_enable
		|-> res1 == $past(cmp_one_raw, 2))
		else $error("synchroniser latency wrong");
	irq_lvl_a: assert property (@(posedge clk) disable iff (rst)
		ce && clr == 6'h00 && |(s_reg.stat & s_reg.irq_en) |=> irq)
		else $error("interrupt not raised");
	cmp_edge_a: assert property (@(posedge clk) disable iff (rst)
		ce && res3 && !s_reg.c3_prev |=> s_reg.stat[5])
		else $error("comparator three edge not flagged");
	stat_clr_a: assert property (@(posedge clk) disable iff (rst)
		ce && clr[4] && !ev[4] |=> !s_reg.stat[4])
		else $error("status clear ignored");
	rd_idle_a: assert property (@(posedge clk) disable iff (rst)
		ce && !rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");
	ce_hold_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(s_reg))
		else $error("state moved while clock enable low");
endmodule : cmx_ctrl
`default_nettype wire

//--- test/comparator_and_ext_input_ctrl_test.sv
// bench: register model compared with the control block
`timescale 1ns/1ps
`default_nettype none
module comparator_and_ext_input_ctrl_test
	import cmx_pkg::*;
;
	logic clk, rst, ce, wr, rd, c1, c3, ie1, ie3, irq;
	logic [9:0] addr;
	logic [7:0] wdata, rdata, d, got;
	logic [3:0] ext, rpf;
	logic [31:0] seed = 32'h4690;
	logic [9:0] reset_addr [5] = '{10'h1F8, 10'h1FA, 10'h1FC, 10'h1FE,
		10'h000};
	int miscompares = 0, checks = 0, cyc = 0;
	cmx_ctrl cmx_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_one_raw(c1),
		.cmp_three_raw(c3), .ext_in_raw(ext), .cmp_one_enable(ie1),
		.cmp_three_enable(ie3), .request_pending_flag(rpf), .irq(irq));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (e !== g) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wreg(logic [9:0] a, logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(logic [9:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
		chk("rdata", e, got);
	endtask : rchk
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		{rst, ce, wr, rd, c1, c3, ext, addr, wdata} = '0;
		rst = 1'b1; ce = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		//==========================================
		// reset values and unmapped place
		foreach (reset_addr[i])
			rchk(reset_addr[i], 8'h00);
		//==========================================
		// comparator enables and synchronised results
		repeat (6) begin
			d = 8'(xs());
			wreg(CMX_CMP_CTRL_OFS, d);
			c1 <= d[6]; c3 <= d[7];
			repeat (4) @(posedge clk);
			rchk(CMX_CMP_CTRL_OFS, (d & 8'h11) | {d[7] & d[4], 3'b0,
				d[6] & d[0], 3'b0});
			chk("enables", {6'b0, d[4], d[0]}, {6'b0, ie3, ie1});
		end
		//==========================================
		// input enable register read back
		repeat (4) begin
			d = 8'(xs());
			wreg(CMX_EXT_EN_OFS, d);
			rchk(CMX_EXT_EN_OFS, d);
		end
		//==========================================
		// spurious request, edges and interrupt
		wreg(CMX_EXT_EN_OFS, 8'h00);
		wreg(CMX_IRQ_CLR_OFS, 8'hFF);
		wreg(CMX_EXT_EN_OFS, 8'h55);
		repeat (2) @(posedge clk);
		#1 chk("spurious", 8'h0F, {4'b0, rpf});
		wreg(CMX_IRQ_CLR_OFS, 8'hFF);
		wreg(CMX_IRQ_EN_OFS, 8'h01);
		#1 chk("irq_idle", 8'h00, {7'b0, irq});
		@(posedge clk);
		ext[0] <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk("rise", 8'h03, {6'b0, irq, rpf[0]});
		wreg(CMX_POL_OFS, 8'h00);
		wreg(CMX_EXT_EN_OFS, 8'h57);
		wreg(CMX_IRQ_CLR_OFS, 8'hFF);
		ext[0] <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk("both", 8'h03, {6'b0, irq, rpf[0]});
		wreg(CMX_IRQ_EN_OFS, 8'h00);
		@(posedge clk);
		#1 chk("masked", 8'h01, {6'b0, irq, rpf[0]});
		//==========================================
		// clock enable low freezes a write
		@(posedge clk);
		ce <= 1'b0;
		wreg(CMX_IRQ_EN_OFS, 8'h3F);
		ce <= 1'b1;
		rchk(CMX_IRQ_EN_OFS, 8'h00);
		//==========================================
		// comparator rising edges set status bits 4 and 5
		wreg(CMX_CMP_CTRL_OFS, 8'h11);
		c1 <= 1'b0; c3 <= 1'b0;
		repeat (4) @(posedge clk);
		wreg(CMX_IRQ_CLR_OFS, 8'hFF);
		c1 <= 1'b1; c3 <= 1'b1;
		repeat (4) @(posedge clk);
		rchk(CMX_IRQ_STAT_OFS, 8'h30);
		wreg(CMX_IRQ_CLR_OFS, 8'hFF);
		rchk(CMX_IRQ_STAT_OFS, 8'h00);
		print_verdict();
	end
endmodule : comparator_and_ext_input_ctrl_test
`default_nettype wire
